//--- logic/ccp_params.svh
// Register offsets, field positions, fuse codes and timing counts of the clock control block
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH
`define CCP_OFS_PLL_CSR 5'h00
`define CCP_OFS_RC_TRIM 5'h04
`define CCP_OFS_SLEEP 5'h08
`define CCP_OFS_TIMER 5'h0C
`define CCP_OFS_STATUS 5'h10
`define CCP_OFS_FREQ 5'h14
`define CCP_BIT_PLL_LOCK 0
`define CCP_BIT_PLL_EN 1
`define CCP_BIT_SLEEP_GO 4
`define CCP_CLOCK_SELECT_FUSES_EXT 4'h0
`define CCP_CLOCK_SELECT_FUSES_PLL 4'h1
`define CCP_CLOCK_SELECT_FUSES_RC8 4'h2
`define CCP_CLOCK_SELECT_FUSES_RC64 4'h3
`define CCP_CLOCK_SELECT_FUSES_WDT 4'h4
`define CCP_CLOCK_SELECT_FUSES_RSV5 4'h5
`define CCP_CLOCK_SELECT_FUSES_LFXO 4'h6
`define CCP_CLOCK_SELECT_FUSES_RSV7 4'h7
`define CCP_DEF_CLOCK_SELECT_FUSES 4'h2
`define CCP_DEF_SUT 2'h2
`define CCP_DEF_DIV8 1'h0
`define CCP_SUT_SHORT 2'h0
`define CCP_WDT_SHORT_CYC 14'h0200
`define CCP_RC8_KHZ 18'h01F40
`define CCP_RC64_KHZ 18'h01900
`define CCP_RC_LIMIT_KHZ 18'h01F40
`define CCP_PCK_MAX_KHZ 18'h14C08
`define CCP_TRIM_STEP_KHZ 18'h00028
`define CCP_MULT_NORMAL 4'h8
`define CCP_MULT_COMPAT 4'h4
`define CCP_CLK_PERIOD_NS 50
`define CCP_PLL_LOCK_NS 100000
`define CCP_PLL_LOCK_CYC ((`CCP_PLL_LOCK_NS + `CCP_CLK_PERIOD_NS - 1) / `CCP_CLK_PERIOD_NS)
`endif

//--- logic/ccp_pkg.sv
// Types shared by the clock control block
package ccp_pkg;
	typedef enum logic [3:0] {
		ST_RESET_DLY = 4'h1,
		ST_STARTUP = 4'h2,
		ST_RUN = 4'h4,
		ST_SLEEP = 4'h8
	} ccp_state_type;
	typedef enum logic [2:0] {
		SLP_IDLE = 3'h0,
		SLP_ADC_NR = 3'h1,
		SLP_POWER_DOWN = 3'h2,
		SLP_POWER_SAVE = 3'h3,
		SLP_STANDBY = 3'h4
	} ccp_sleep_type;
	typedef enum logic [2:0] {
		SRC_EXT = 3'h0,
		SRC_PLL = 3'h1,
		SRC_RC8 = 3'h2,
		SRC_RC64 = 3'h3,
		SRC_WDT = 3'h4,
		SRC_LFXO = 3'h5,
		SRC_XTAL = 3'h6
	} ccp_src_type;
endpackage

//--- logic/ccp_sync_edge.sv
// Two-stage synchroniser with rising-edge pulse for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ccp_sync_edge #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	// Chain left unreset so fuse levels settle while reset is held
	always_ff @(posedge i_clk)
	begin
		s1_r <= i_async;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end
	// Edge logic reads only the second and third stages
	assign o_level = s2_r;
	assign o_rise = s2_r & ~s3_r;
endmodule
`default_nettype wire

//--- logic/ccp_pll_model.sv
// Behavioural PLL: tracks the RC frequency, multiplies it and reports lock
`timescale 1ns/100ps
`default_nettype none
`include "ccp_params.svh"
module ccp_pll_model
	import ccp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_run,
	input wire logic i_compat,
	input wire logic [7:0] i_trim,
	input wire logic [7:0] i_cal,
	output logic o_lock,
	output logic [16:0] o_freq_khz,
	output logic [3:0] o_mult
);
	logic [11:0] lock_cnt_r;
	logic [11:0] lock_cnt_nxt;
	logic [17:0] nom;
	logic [17:0] up;
	logic [17:0] dn;
	logic [17:0] rc;
	logic [17:0] prod;
	logic [3:0] mult_nxt;
	logic over;
	logic [16:0] freq_nxt;
	// RC frequency follows the trim relative to the factory byte
	assign nom = i_compat ? `CCP_RC64_KHZ : `CCP_RC8_KHZ; // R03
	assign up = nom + (18'(i_trim) * `CCP_TRIM_STEP_KHZ); // R06
	assign dn = 18'(i_cal) * `CCP_TRIM_STEP_KHZ;
	assign rc = (up > dn) ? (up - dn) : 18'h00000;
	assign mult_nxt = i_compat ? `CCP_MULT_COMPAT : `CCP_MULT_NORMAL; // R02 R03
	assign prod = rc * 18'(mult_nxt);
	// Above the RC limit the loop can no longer follow its reference
	assign over = rc > `CCP_RC_LIMIT_KHZ; // R06
	assign lock_cnt_nxt = (!i_run || over) ? 12'h000 :
		(lock_cnt_r == 12'(`CCP_PLL_LOCK_CYC)) ? lock_cnt_r : lock_cnt_r + 12'h001;
	// Output saturates rather than running away
	assign freq_nxt = !i_run ? 17'h00000 :
		(prod > `CCP_PCK_MAX_KHZ) ? 17'(`CCP_PCK_MAX_KHZ) : prod[16:0]; // R06
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			lock_cnt_r <= 12'h000;
			o_lock <= 1'b0;
			o_freq_khz <= 17'h00000;
			o_mult <= `CCP_MULT_NORMAL;
		end
		else
		begin
			lock_cnt_r <= lock_cnt_nxt;
			o_lock <= lock_cnt_nxt == 12'(`CCP_PLL_LOCK_CYC); // R05
			o_freq_khz <= freq_nxt;
			o_mult <= mult_nxt;
		end
	end
endmodule
`default_nettype wire

//--- logic/ccp_clock_control.sv
// Clock source selection, PLL control, domain gating and start-up timing
// Contract
// R01 - Pick the system clock source from the four-bit fuse code.
// R02 - PLL multiplies the 8 MHz RC by eight, giving 64 MHz.
// R03 - Code 0011 trims RC to 6.4 MHz and uses times four.
// R04 - PLL runs only if enable bit set or PLL fuse programmed.
// R05 - Lock flag is set once the PLL has locked.
// R06 - Trim moves the fast clock; saturates at 85 MHz, loses lock above 8 MHz.
// R07 - Software keeps the RC trim at or below 8 MHz.
// R08 - RC oscillator and PLL stop in power-down and stand-by.
// R09 - Fast clock or a prescaled form is selectable for the fast timer.
// R10 - Wake from power-down or power-save times a start-up interval first.
// R11 - Reset adds 512 or 8192 watchdog cycles of settling delay.
// R12 - Unused clock domains halt through the sleep modes.
// R13 - Halting the core clock stops core register and stack logic.
// R14 - I/O clock feeds peripherals; async interrupt detect works while halted.
// R15 - Converter clock keeps running while core and I/O clocks halt.
// R16 - Program memory clock runs together with the core clock.
// R17 - Delivered default: RC 8 MHz, longest start-up, divide by eight.
// R18 - Reset loads the factory calibration byte into the RC trim.
// R19 - Reserved fuse codes never switch the clock to an undefined source.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_params.svh"
module ccp_clock_control
	import ccp_pkg::*;
#(
	parameter int WDT_LONG_CYC = 8192,
	parameter int STARTUP_CK = 1024
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic [4:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic [3:0] I_CLOCK_SELECT_FUSES,
	input wire logic [1:0] I_STARTUP_TIME_FUSES,
	input wire logic I_PLL_CLOCK_FUSE,
	input wire logic I_DIVIDE_BY_EIGHT_FUSE,
	input wire logic I_FUSES_BLANK,
	input wire logic [7:0] I_CAL_BYTE,
	input wire logic I_WDT_OSC_TICK,
	input wire logic I_SRC_OSC_TICK,
	input wire logic I_WAKE_EVENT,
	output logic [2:0] O_SYS_CLK_SRC,
	output logic O_SYS_DIV8,
	output logic O_CORE_CLK_EN,
	output logic O_IO_CLK_EN,
	output logic O_FLASH_CLK_EN,
	output logic O_ADC_CLK_EN,
	output logic O_ASYNC_INT_EN,
	output logic O_RC_OSC_EN,
	output logic O_PLL_EN,
	output logic O_PLL_LOCK,
	output logic [16:0] O_PCK_FREQ_KHZ,
	output logic [3:0] O_PLL_MULT,
	output logic O_TIMER_PCK_SEL,
	output logic [1:0] O_TIMER_PRESCALE,
	output logic [7:0] O_RC_TRIM
);
	// Reserved codes are refused as a source
	function automatic logic fuse_reserved(input logic [3:0] c);
		fuse_reserved = (c == `CCP_CLOCK_SELECT_FUSES_RSV5) || (c == `CCP_CLOCK_SELECT_FUSES_RSV7);
	endfunction

	function automatic ccp_src_type src_decode(input logic [3:0] c);
		if (c[3])
			src_decode = SRC_XTAL;
		else
			case (c)
				`CCP_CLOCK_SELECT_FUSES_EXT: src_decode = SRC_EXT;
				`CCP_CLOCK_SELECT_FUSES_PLL: src_decode = SRC_PLL;
				`CCP_CLOCK_SELECT_FUSES_RC64: src_decode = SRC_RC64;
				`CCP_CLOCK_SELECT_FUSES_WDT: src_decode = SRC_WDT;
				`CCP_CLOCK_SELECT_FUSES_LFXO: src_decode = SRC_LFXO;
				default: src_decode = SRC_RC8;
			endcase
	endfunction

	logic [16:0] fz_lvl;
	logic [2:0] tk_rise;
	logic [2:0] tk_lvl;
	logic [3:0] clock_select_fuses_in;
	logic [1:0] sut_in;
	logic div8_in;
	logic [3:0] clock_select_fuses_r;
	logic [1:0] sut_r;
	logic pll_fuse_r;
	logic div8_r;
	logic [7:0] cal_r;
	ccp_src_type src_r;
	ccp_state_type state_r;
	ccp_state_type state_nxt;
	ccp_sleep_type mode_r;
	logic [13:0] cnt_r;
	logic [13:0] cnt_nxt;
	logic [13:0] dly_last;
	logic pll_bit_r;
	logic wait_r;
	logic wdt_tick;
	logic src_tick;
	logic wake;
	logic deep_off;
	logic wake_deep;
	logic run_st;
	logic slp_st;
	logic req;
	logic wr_do;
	logic [4:0] ofs;
	logic sel_csr;
	logic sel_trim;
	logic sel_sleep;
	logic sel_timer;
	logic sel_sts;
	logic sel_freq;
	logic sleep_go;
	logic [31:0] rmux;
	logic rc_nxt;
	logic pll_nxt;
	logic io_nxt;
	logic adc_nxt;

	// Fuse pins and calibration byte cross into the clock domain
	ccp_sync_edge #(.W(17)) u_fuse_sync (
		.i_clk(I_CLK_SYS),
		.i_async({I_CAL_BYTE, I_FUSES_BLANK, I_DIVIDE_BY_EIGHT_FUSE, I_PLL_CLOCK_FUSE,
			I_STARTUP_TIME_FUSES, I_CLOCK_SELECT_FUSES}),
		.o_level(fz_lvl),
		.o_rise()
	);

	// Oscillator ticks and wake-up event
	ccp_sync_edge #(.W(3)) u_tick_sync (
		.i_clk(I_CLK_SYS),
		.i_async({I_WAKE_EVENT, I_SRC_OSC_TICK, I_WDT_OSC_TICK}),
		.o_level(tk_lvl),
		.o_rise(tk_rise)
	);

	assign wdt_tick = tk_rise[0];
	assign src_tick = tk_rise[1];
	assign wake = tk_lvl[2];

	// A blank fuse array reads as the delivered clock select, start-up and divide-by-eight settings; the PLL fuse is taken from its pin
	assign clock_select_fuses_in = fz_lvl[8] ? `CCP_DEF_CLOCK_SELECT_FUSES : fz_lvl[3:0]; // R17
	assign sut_in = fz_lvl[8] ? `CCP_DEF_SUT : fz_lvl[5:4]; // R17
	assign div8_in = fz_lvl[8] ? `CCP_DEF_DIV8 : fz_lvl[7]; // R17

	// Fuses and calibration are captured while reset is held
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			clock_select_fuses_r <= clock_select_fuses_in;
			sut_r <= sut_in;
			pll_fuse_r <= fz_lvl[6];
			div8_r <= div8_in;
			cal_r <= fz_lvl[16:9];
			src_r <= src_decode(clock_select_fuses_in); // R01 R19
		end
	end

	// Bus decode; low address bits are ignored
	assign req = I_AVS_READ | I_AVS_WRITE;
	assign ofs = {I_AVS_ADDRESS[4:2], 2'b00};
	assign sel_csr = ofs == `CCP_OFS_PLL_CSR;
	assign sel_trim = ofs == `CCP_OFS_RC_TRIM;
	assign sel_sleep = ofs == `CCP_OFS_SLEEP;
	assign sel_timer = ofs == `CCP_OFS_TIMER;
	assign sel_sts = ofs == `CCP_OFS_STATUS;
	assign sel_freq = ofs == `CCP_OFS_FREQ;
	assign wr_do = I_AVS_WRITE & ~wait_r & I_AVS_BYTEENABLE[0];
	// Sleep requests outside the run state are dropped
	assign sleep_go = wr_do & sel_sleep & I_AVS_WRITEDATA[`CCP_BIT_SLEEP_GO] & run_st; // R12

	// Read mux; unmapped offsets read zero
	assign rmux = sel_csr ? {30'h00000000, pll_bit_r, O_PLL_LOCK} : // R05
		sel_trim ? {24'h000000, O_RC_TRIM} :
		sel_sleep ? {29'h00000000, mode_r} :
		sel_timer ? {29'h00000000, O_TIMER_PRESCALE, O_TIMER_PCK_SEL} :
		sel_sts ? {23'h000000, state_r, div8_r, fuse_reserved(clock_select_fuses_r), src_r} :
		sel_freq ? {15'h0000, O_PCK_FREQ_KHZ} : 32'h00000000;

	// One wait cycle per access keeps the answer registered
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			wait_r <= 1'b1;
			O_AVS_READDATA <= 32'h00000000;
		end
		else
		begin
			wait_r <= ~(req & wait_r);
			O_AVS_READDATA <= (I_AVS_READ & wait_r) ? rmux : 32'h00000000;
		end
	end
	assign O_AVS_WAITREQUEST = wait_r;

	// Software registers
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			pll_bit_r <= 1'b0;
			O_RC_TRIM <= fz_lvl[16:9]; // R18
			mode_r <= SLP_IDLE;
			O_TIMER_PCK_SEL <= 1'b0;
			O_TIMER_PRESCALE <= 2'h0;
		end
		else
		begin
			if (wr_do & sel_csr)
				pll_bit_r <= I_AVS_WRITEDATA[`CCP_BIT_PLL_EN];
			if (wr_do & sel_trim)
				O_RC_TRIM <= I_AVS_WRITEDATA[7:0]; // R06
			if (sleep_go)
				mode_r <= (I_AVS_WRITEDATA[2:0] > SLP_STANDBY) ? SLP_IDLE : ccp_sleep_type'(I_AVS_WRITEDATA[2:0]);
			if (wr_do & sel_timer)
			begin
				O_TIMER_PCK_SEL <= I_AVS_WRITEDATA[0]; // R09
				O_TIMER_PRESCALE <= I_AVS_WRITEDATA[2:1]; // R09
			end
		end
	end

	// Settling delay target follows the start-up fuses
	assign dly_last = (sut_r == `CCP_SUT_SHORT) ? (`CCP_WDT_SHORT_CYC - 14'h0001) : 14'(WDT_LONG_CYC - 1); // R11
	assign run_st = state_r == ST_RUN;
	assign slp_st = state_r == ST_SLEEP;
	assign deep_off = (mode_r == SLP_POWER_DOWN) || (mode_r == SLP_STANDBY);
	assign wake_deep = (mode_r == SLP_POWER_DOWN) || (mode_r == SLP_POWER_SAVE);

	// Start-up sequencer
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_RESET_DLY:
				if (wdt_tick)
				begin
					if (cnt_r == dly_last)
					begin
						state_nxt = ST_STARTUP; // R11
						cnt_nxt = 14'h0000;
					end
					else
						cnt_nxt = cnt_r + 14'h0001;
				end
			ST_STARTUP:
				if (src_tick)
				begin
					if (cnt_r == 14'(STARTUP_CK - 1))
					begin
						state_nxt = ST_RUN; // R10
						cnt_nxt = 14'h0000;
					end
					else
						cnt_nxt = cnt_r + 14'h0001;
				end
			ST_RUN:
				if (sleep_go)
					state_nxt = ST_SLEEP; // R12
			ST_SLEEP:
				if (wake)
				begin
					state_nxt = wake_deep ? ST_STARTUP : ST_RUN; // R10
					cnt_nxt = 14'h0000;
				end
			default:
			begin
				state_nxt = ST_RESET_DLY;
				cnt_nxt = 14'h0000;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			state_r <= ST_RESET_DLY;
			cnt_r <= 14'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Domain enables; the converter keeps its clock in noise-reduction sleep
	assign io_nxt = run_st | (slp_st & (mode_r == SLP_IDLE)); // R14
	assign adc_nxt = run_st | (slp_st & ((mode_r == SLP_IDLE) | (mode_r == SLP_ADC_NR))); // R15
	assign rc_nxt = ~(slp_st & deep_off); // R08
	assign pll_nxt = rc_nxt & (pll_bit_r | ~pll_fuse_r); // R04 R08

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			O_CORE_CLK_EN <= 1'b0;
			O_FLASH_CLK_EN <= 1'b0;
			O_IO_CLK_EN <= 1'b0;
			O_ADC_CLK_EN <= 1'b0;
			O_ASYNC_INT_EN <= 1'b1;
			O_RC_OSC_EN <= 1'b1;
			O_PLL_EN <= 1'b0;
			O_SYS_CLK_SRC <= SRC_RC8;
			O_SYS_DIV8 <= 1'b0;
		end
		else
		begin
			O_CORE_CLK_EN <= run_st; // R13
			O_FLASH_CLK_EN <= run_st; // R16
			O_IO_CLK_EN <= io_nxt; // R14
			O_ADC_CLK_EN <= adc_nxt; // R15
			O_ASYNC_INT_EN <= ~io_nxt; // R14
			O_RC_OSC_EN <= rc_nxt; // R08
			O_PLL_EN <= pll_nxt; // R04
			O_SYS_CLK_SRC <= src_r; // R01
			O_SYS_DIV8 <= ~div8_r; // R17
		end
	end

	// Compatibility code scales both the RC and the multiplier
	ccp_pll_model u_pll (
		.i_clk(I_CLK_SYS),
		.i_reset_n(I_RESET_N),
		.i_run(O_PLL_EN),
		.i_compat(src_r == SRC_RC64),
		.i_trim(O_RC_TRIM),
		.i_cal(cal_r),
		.o_lock(O_PLL_LOCK),
		.o_freq_khz(O_PCK_FREQ_KHZ),
		.o_mult(O_PLL_MULT)
	);

	default clocking @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RESET_N);

	sequence bus_req_s;
		req && O_AVS_WAITREQUEST;
	endsequence
	sequence deep_sleep_s;
		slp_st && deep_off;
	endsequence
	sequence deep_wake_s;
		slp_st && wake && wake_deep;
	endsequence

	bus_answer_a: assert property (bus_req_s |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
		else $error("bus answer not after one wait cycle");
	pll_run_a: assert property (O_PLL_EN |-> $past(pll_bit_r | ~pll_fuse_r)) // R04
		else $error("PLL running without enable");
	lock_cause_a: assert property ($rose(O_PLL_LOCK) |-> $past(O_PLL_EN, 2)) // R05
		else $error("lock without running PLL");
	rc_stop_a: assert property (deep_sleep_s |=> !O_RC_OSC_EN && !O_PLL_EN) // R08
		else $error("RC or PLL left running in deep sleep");
	compat_mult_a: assert property ((src_r == SRC_RC64) |=> O_PLL_MULT == `CCP_MULT_COMPAT) // R03
		else $error("compat mode not times four");
	normal_mult_a: assert property ((src_r != SRC_RC64) |=> O_PLL_MULT == `CCP_MULT_NORMAL) // R02
		else $error("normal mode not times eight");
	freq_sat_a: assert property (O_PCK_FREQ_KHZ <= 17'(`CCP_PCK_MAX_KHZ)) // R06
		else $error("fast clock above saturation");
	reset_dly_a: assert property (state_r == ST_RESET_DLY && wdt_tick && cnt_r == dly_last |=> state_r == ST_STARTUP) // R11
		else $error("settling delay end missed");
	wake_start_a: assert property (deep_wake_s |=> state_r == ST_STARTUP ##1 !O_CORE_CLK_EN) // R10
		else $error("wake skipped start-up");
	adc_run_a: assert property (slp_st && mode_r == SLP_ADC_NR |=> O_ADC_CLK_EN && !O_CORE_CLK_EN && !O_IO_CLK_EN) // R15
		else $error("converter domain gating wrong");
	flash_core_a: assert property (O_FLASH_CLK_EN == O_CORE_CLK_EN) // R16
		else $error("flash and core enables differ");
	async_int_a: assert property (O_ASYNC_INT_EN == !O_IO_CLK_EN) // R14
		else $error("async detect not tied to I/O halt");
	reserved_src_a: assert property (fuse_reserved(clock_select_fuses_r) |-> O_SYS_CLK_SRC == SRC_RC8) // R19
		else $error("reserved code selected a source");
endmodule
`default_nettype wire

//--- bench/ccp_osc_model.sv
// Oscillator pin model feeding watchdog and source ticks to the clock control block
`timescale 1ns/100ps
`default_nettype none
module ccp_osc_model
(
	input wire logic i_clk,
	input wire logic i_src_run,
	output logic o_wdt_tick,
	output logic o_src_tick
);
	logic [1:0] div_r = 2'h0;
	logic src_tick_r = 1'b0;

	// Free-running divider: each tick level lasts two system clocks, the minimum the synchroniser needs
	always_ff @(posedge i_clk)
	begin
		div_r <= div_r + 2'h1;
	end

	// Watchdog oscillator never stops, so the reset delay always gets its ticks
	assign o_wdt_tick = div_r[1];

	// Source pin stands still while the RC oscillator is off, so start-up waits for restart
	always_ff @(posedge i_clk)
	begin
		if (i_src_run)
			src_tick_r <= div_r[1];
	end
	assign o_src_tick = src_tick_r;
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking testbench for the clock control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
`define WAIT_FOR(cond, lim) begin n = 0; while (!(cond) && n < (lim)) begin @(posedge clk_sys); n++; end \
	if (n >= (lim)) miscompares++; end
module testbench
	import ccp_pkg::*;
;
	localparam logic [7:0] CAL = 8'h5A;
	logic clk_sys = 1'b0;
	logic reset_n, avs_read, avs_write, pll_fuse, div8_fuse, blank, wake, wdt_tick, src_tick;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	logic [3:0] avs_byteenable, clock_select_fuses, pll_mult;
	logic [1:0] startup_time_fuses, timer_pre;
	logic waitreq, sys_div8, core_en, io_en, flash_en, adc_en, async_en, rc_en, pll_en, pll_lock, timer_sel;
	logic [2:0] sys_src;
	logic [16:0] pck_khz;
	logic [7:0] rc_trim;
	logic [5:0] slp_exp [5] = '{6'h0F, 6'h07, 6'h00, 6'h03, 6'h00};
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int n, c, m;

	always #25 clk_sys = ~clk_sys;

	// Short counts keep the reset delay and start-up inside a short run
	ccp_clock_control #(.WDT_LONG_CYC(16), .STARTUP_CK(4)) dut (
		.I_CLK_SYS(clk_sys), .I_RESET_N(reset_n), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
		.I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata), .I_AVS_BYTEENABLE(avs_byteenable),
		.O_AVS_READDATA(avs_readdata), .O_AVS_WAITREQUEST(waitreq), .I_CLOCK_SELECT_FUSES(clock_select_fuses),
		.I_STARTUP_TIME_FUSES(startup_time_fuses), .I_PLL_CLOCK_FUSE(pll_fuse), .I_DIVIDE_BY_EIGHT_FUSE(div8_fuse),
		.I_FUSES_BLANK(blank), .I_CAL_BYTE(CAL), .I_WDT_OSC_TICK(wdt_tick), .I_SRC_OSC_TICK(src_tick),
		.I_WAKE_EVENT(wake), .O_SYS_CLK_SRC(sys_src), .O_SYS_DIV8(sys_div8), .O_CORE_CLK_EN(core_en),
		.O_IO_CLK_EN(io_en), .O_FLASH_CLK_EN(flash_en), .O_ADC_CLK_EN(adc_en), .O_ASYNC_INT_EN(async_en),
		.O_RC_OSC_EN(rc_en), .O_PLL_EN(pll_en), .O_PLL_LOCK(pll_lock), .O_PCK_FREQ_KHZ(pck_khz),
		.O_PLL_MULT(pll_mult), .O_TIMER_PCK_SEL(timer_sel), .O_TIMER_PRESCALE(timer_pre), .O_RC_TRIM(rc_trim));

	ccp_osc_model u_osc (.i_clk(clk_sys), .i_src_run(rc_en), .o_wdt_tick(wdt_tick), .o_src_tick(src_tick));

	// One bus access; request held until waitrequest is seen low at a rising edge, the hang guard ends a stuck wait
	task bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_write <= wr;
		avs_read <= ~wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge clk_sys);
		while (waitreq !== 1'b0)
			@(posedge clk_sys);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Fuses are sampled during reset, so they are applied with it and held after
	task do_reset(input logic [3:0] code, input logic [1:0] s, input logic pf, input logic bl);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		clock_select_fuses <= code;
		startup_time_fuses <= s;
		pll_fuse <= pf;
		blank <= bl;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask

	function automatic ccp_src_type exp_src(input logic [3:0] code);
		case (code)
			4'h0: return SRC_EXT;
			4'h1: return SRC_PLL;
			4'h3: return SRC_RC64;
			4'h4: return SRC_WDT;
			4'h6: return SRC_LFXO;
			default: return code[3] ? SRC_XTAL : SRC_RC8;
		endcase
	endfunction

	task conclude;
		$display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard: the whole sequence needs about nine thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			conclude();
		end
	end

	initial
	begin
		reset_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		clock_select_fuses = 4'hF;
		startup_time_fuses = 2'h3;
		pll_fuse = 1'b1;
		div8_fuse = 1'b1;
		blank = 1'b1;
		wake = 1'b0;
		// Blank array falls back to the delivered setting
		do_reset(4'hF, 2'h3, 1'b1, 1'b1);
		`CHK(sys_src, SRC_RC8)
		`CHK(sys_div8, 1'b1)
		`CHK(rc_trim, CAL)
		// Every fuse code, reserved ones included
		for (c = 0; c < 16; c++)
		begin
			do_reset(c[3:0], 2'h1, 1'b1, 1'b0);
			`CHK(sys_src, exp_src(c[3:0]))
			`CHK(pll_mult, (c == 3) ? 4'h4 : 4'h8)
			bus_xfer(1'b0, 5'h10, 32'h0, 4'hF);
			`CHK(rdata[3], (c == 5 || c == 7))
		end
		// Compatibility mode with the PLL forced on by its fuse
		do_reset(4'h3, 2'h1, 1'b0, 1'b0);
		`CHK(pll_en, 1'b1)
		`WAIT_FOR(pll_lock === 1'b1, 2200)
		`CHK(pck_khz, 17'h06400)
		// Short reset time-out counts 512 watchdog ticks before running
		do_reset(4'h2, 2'h0, 1'b1, 1'b0);
		repeat (1500) @(posedge clk_sys);
		`CHK(core_en, 1'b0)
		`WAIT_FOR(core_en === 1'b1, 1500)
		`CHK(core_en, 1'b1)
		`CHK(pll_en, 1'b0)
		bus_xfer(1'b1, 5'h00, 32'h2, 4'hF);
		repeat (1900) @(posedge clk_sys);
		`CHK(pll_lock, 1'b0)
		`WAIT_FOR(pll_lock === 1'b1, 300)
		bus_xfer(1'b0, 5'h00, 32'h0, 4'hF);
		`CHK(rdata[1:0], 2'h3)
		`CHK(pck_khz, 17'h0FA00)
		bus_xfer(1'b1, 5'h00, 32'h0, 4'h0);
		bus_xfer(1'b0, 5'h00, 32'h0, 4'hF);
		`CHK(rdata[1:0], 2'h3)
		bus_xfer(1'b1, 5'h18, 32'hFFFFFFFF, 4'hF);
		bus_xfer(1'b0, 5'h18, 32'h0, 4'hF);
		`CHK(rdata, 32'h0)
		// One trim step above nominal pushes the RC past 8 MHz: lock lost, output still follows
		bus_xfer(1'b1, 5'h04, {24'h0, CAL + 8'h01}, 4'hF);
		repeat (20) @(posedge clk_sys);
		`CHK(pll_lock, 1'b0)
		`CHK(pck_khz, 17'h0FB40)
		// Far above nominal the product would pass 85 MHz, so the output saturates
		bus_xfer(1'b1, 5'h04, {24'h0, CAL + 8'h50}, 4'hF);
		repeat (20) @(posedge clk_sys);
		`CHK(pll_lock, 1'b0)
		`CHK(pck_khz, 17'h14C08)
		bus_xfer(1'b1, 5'h04, {24'h0, CAL - 8'h01}, 4'hF);
		`WAIT_FOR(pll_lock === 1'b1, 2200)
		`CHK(pck_khz, 17'h0F8C0)
		bus_xfer(1'b1, 5'h0C, 32'h5, 4'hF);
		// The write lands at the edge the task returns on, so look one edge later
		@(posedge clk_sys);
		`CHK(timer_sel, 1'b1)
		`CHK(timer_pre, 2'h2)
		// Each sleep mode gates its domains, then a wake event restores them
		for (m = 0; m < 5; m++)
		begin
			bus_xfer(1'b1, 5'h08, 32'h10 | 32'(m), 4'hF);
			repeat (4) @(posedge clk_sys);
			`CHK({core_en, flash_en, io_en, adc_en, rc_en, pll_en}, slp_exp[m])
			`CHK(async_en, ~io_en)
			@(posedge clk_sys);
			wake <= 1'b1;
			repeat (8) @(posedge clk_sys);
			`CHK(core_en, (m != 2 && m != 3))
			`WAIT_FOR(core_en === 1'b1, 200)
			`CHK({core_en, flash_en, io_en, adc_en}, 4'hF)
			wake <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
		conclude();
	end
endmodule
`default_nettype wire
